// File: design/fppio_pin_sync.sv
// three-flop pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/100ps
module fppio_pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] filt;
    } fppio_sync_state_t;

    fppio_sync_state_t st_ff;
    fppio_sync_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_i;
        // s1 feeds s2 only; the filter looks at s2 and s3
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.filt[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_o = st_ff.filt;
endmodule

// File: design/fppio_top.sv
// four-port parallel i/o block with an avalon-mm register slave
`timescale 1ns/100ps
`include "fppio_map.svh"

// How it works
// - ports a, b and c are 8-bit two-way ports whose data registers sit at indexes 0, 1 and 2.
// - each two-way port has a direction register, at index 4 for a, 5 for b and 6 for c.
// - reset clears every direction register so all two-way pins become inputs.
// - reset leaves every port data register, the input-only one included, untouched.
// - a one written to a direction bit turns the matching pin into an output.
// - port d is an 8-bit input-only port read at index 3 and has no direction register.
// - port d pins 7:6 go to the two-wire unit, 5:2 to the sync serial unit, 1:0 to the uart.
// - while reset is held low every pin is in its single-chip state, an undriven input.
// - pins of ports a, b and c are only ever driven by this port logic.
module fppio_top (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // avalon-mm slave, byte address
    input wire logic [`FPPIO_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // two-way ports
    input wire logic [7:0] port_a_pin_i,
    output logic [7:0] port_a_pin_o,
    output logic [7:0] port_a_pin_oe_b_o,
    input wire logic [7:0] port_b_pin_i,
    output logic [7:0] port_b_pin_o,
    output logic [7:0] port_b_pin_oe_b_o,
    input wire logic [7:0] port_c_pin_i,
    output logic [7:0] port_c_pin_o,
    output logic [7:0] port_c_pin_oe_b_o,
    // input-only port and its shared serial taps
    input wire logic [7:0] input_port_pin_i,
    output fppio_pkg::fppio_share_t input_port_share_o
);

    fppio_pkg::fppio_state_t st_ff;
    fppio_pkg::fppio_state_t nxt_st;
    fppio_pkg::fppio_pins_t pins_raw;
    fppio_pkg::fppio_pins_t pins_sync;

    // byte address to register index; low two bits select a lane and are ignored
    function automatic logic [`FPPIO_IDX_W-1:0] reg_index(
        input logic [`FPPIO_ADDR_W-1:0] addr
    );
        reg_index = addr[`FPPIO_ADDR_W-1:2];
    endfunction

    // per-bit mux between stored data for outputs and pin level for inputs
    function automatic fppio_pkg::fppio_byte_t port_read(
        input fppio_pkg::fppio_byte_t data,
        input fppio_pkg::fppio_byte_t dir,
        input fppio_pkg::fppio_byte_t pin
    );
        port_read = (data & dir) | (pin & ~dir);
    endfunction

    // one driver for the whole struct; packed order is port c, b, a, then d
    assign pins_raw = {port_c_pin_i, port_b_pin_i, port_a_pin_i, input_port_pin_i};

    // pins come from the board and are asynchronous to mclk_i
    fppio_pin_sync #(
        .WIDTH($bits(fppio_pkg::fppio_pins_t))
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .pin_i(pins_raw),
        .pin_o(pins_sync)
    );

    always_comb begin
        logic [`FPPIO_IDX_W-1:0] idx;
        logic take_req;
        logic do_write;
        fppio_pkg::fppio_byte_t wbyte;
        fppio_pkg::fppio_byte_t rbyte;

        nxt_st = st_ff;
        idx = reg_index(avs_address_i);
        wbyte = avs_writedata_i[7:0];
        rbyte = 8'h00;

        // a request is first seen while waitrequest is high and answered one cycle later
        take_req = (avs_read_i || avs_write_i) && st_ff.waitreq;
        // writes land on the one edge where the master sees waitrequest low
        do_write = avs_write_i && !st_ff.waitreq && avs_byteenable_i[0];

        nxt_st.waitreq = !take_req;

        // port d value tracks its pins; it is held while reset is asserted
        nxt_st.in_d = pins_sync.pins_d;

        if (do_write) begin
            case (idx)
                `FPPIO_IDX_PORT_A_VALUE: begin
                    nxt_st.data[0] = wbyte;
                end
                `FPPIO_IDX_PORT_B_VALUE: begin
                    nxt_st.data[1] = wbyte;
                end
                `FPPIO_IDX_PORT_C_VALUE: begin
                    nxt_st.data[2] = wbyte;
                end
                `FPPIO_IDX_PORT_A_DIRECTION: begin
                    nxt_st.dir[0] = wbyte;
                end
                `FPPIO_IDX_PORT_B_DIRECTION: begin
                    nxt_st.dir[1] = wbyte;
                end
                `FPPIO_IDX_PORT_C_DIRECTION: begin
                    nxt_st.dir[2] = wbyte;
                end
                default: begin
                    // input-only port, unused and unmapped indexes drop the write
                    nxt_st.dir = st_ff.dir;
                end
            endcase
        end

        case (idx)
            `FPPIO_IDX_PORT_A_VALUE: begin
                rbyte = port_read(st_ff.data[0], st_ff.dir[0], pins_sync.pins[0]);
            end
            `FPPIO_IDX_PORT_B_VALUE: begin
                rbyte = port_read(st_ff.data[1], st_ff.dir[1], pins_sync.pins[1]);
            end
            `FPPIO_IDX_PORT_C_VALUE: begin
                rbyte = port_read(st_ff.data[2], st_ff.dir[2], pins_sync.pins[2]);
            end
            `FPPIO_IDX_INPUT_PORT_VALUE: begin
                rbyte = st_ff.in_d;
            end
            `FPPIO_IDX_PORT_A_DIRECTION: begin
                rbyte = st_ff.dir[0];
            end
            `FPPIO_IDX_PORT_B_DIRECTION: begin
                rbyte = st_ff.dir[1];
            end
            `FPPIO_IDX_PORT_C_DIRECTION: begin
                rbyte = st_ff.dir[2];
            end
            default: begin
                rbyte = 8'h00;
            end
        endcase

        // read data is captured once and stands through the answer cycle
        if (take_req && avs_read_i) begin
            nxt_st.rdata = {24'h000000, rbyte};
        end

        // only the port's own data and direction reach the two-way pins
        for (int p = 0; p < 3; p++) begin
            nxt_st.drive[p] = nxt_st.data[p] & nxt_st.dir[p];
            nxt_st.oe_b[p] = ~nxt_st.dir[p];
        end

        nxt_st.share.two_wire =
            pins_sync.pins_d[`FPPIO_TWO_WIRE_MSB:`FPPIO_TWO_WIRE_LSB];
        nxt_st.share.sync_serial =
            pins_sync.pins_d[`FPPIO_SYNC_SERIAL_MSB:`FPPIO_SYNC_SERIAL_LSB];
        nxt_st.share.async_serial =
            pins_sync.pins_d[`FPPIO_ASYNC_SERIAL_MSB:`FPPIO_ASYNC_SERIAL_LSB];
    end

    // data fields get no reset value on purpose so reset keeps their contents
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_ff.dir <= {3{`FPPIO_DIR_RESET}};
            st_ff.oe_b <= {3{`FPPIO_OE_B_RESET}};
            st_ff.drive <= '0;
            st_ff.rdata <= 32'h00000000;
            st_ff.waitreq <= 1'b1;
            st_ff.share <= '0;
            st_ff.data <= st_ff.data;
            st_ff.in_d <= st_ff.in_d;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata_o = st_ff.rdata;
    assign avs_waitrequest_o = st_ff.waitreq;
    assign port_a_pin_o = st_ff.drive[0];
    assign port_b_pin_o = st_ff.drive[1];
    assign port_c_pin_o = st_ff.drive[2];
    assign port_a_pin_oe_b_o = st_ff.oe_b[0];
    assign port_b_pin_oe_b_o = st_ff.oe_b[1];
    assign port_c_pin_oe_b_o = st_ff.oe_b[2];
    assign input_port_share_o = st_ff.share;
endmodule

// File: inc/fppio_map.svh
// register indexes, reset values and bus sizes of the four-port parallel i/o block
`ifndef FPPIO_MAP_SVH
`define FPPIO_MAP_SVH

`define FPPIO_ADDR_W 8
`define FPPIO_IDX_W 6
`define FPPIO_IDX_PORT_A_VALUE 6'h00
`define FPPIO_IDX_PORT_B_VALUE 6'h01
`define FPPIO_IDX_PORT_C_VALUE 6'h02
`define FPPIO_IDX_INPUT_PORT_VALUE 6'h03
`define FPPIO_IDX_PORT_A_DIRECTION 6'h04
`define FPPIO_IDX_PORT_B_DIRECTION 6'h05
`define FPPIO_IDX_PORT_C_DIRECTION 6'h06
`define FPPIO_DIR_RESET 8'h00
`define FPPIO_OE_B_RESET 8'hff
`define FPPIO_SYNC_STAGES 3
`define FPPIO_TWO_WIRE_MSB 7
`define FPPIO_TWO_WIRE_LSB 6
`define FPPIO_SYNC_SERIAL_MSB 5
`define FPPIO_SYNC_SERIAL_LSB 2
`define FPPIO_ASYNC_SERIAL_MSB 1
`define FPPIO_ASYNC_SERIAL_LSB 0

`endif

// File: inc/fppio_pkg.sv
// types shared by the four-port parallel i/o block
package fppio_pkg;

    typedef logic [7:0] fppio_byte_t;

    // input-only port pins as handed to the serial units that share them
    typedef struct packed {
        logic [1:0] two_wire;
        logic [3:0] sync_serial;
        logic [1:0] async_serial;
    } fppio_share_t;

    typedef struct packed {
        fppio_byte_t [2:0] data;
        fppio_byte_t [2:0] dir;
        fppio_byte_t in_d;
        fppio_byte_t [2:0] drive;
        fppio_byte_t [2:0] oe_b;
        logic [31:0] rdata;
        logic waitreq;
        fppio_share_t share;
    } fppio_state_t;

    typedef struct packed {
        fppio_byte_t [2:0] pins;
        fppio_byte_t pins_d;
    } fppio_pins_t;

endpackage

// File: verification/fppio_pin_model.sv
// board circuitry that drives the port pins through weak resistors
`timescale 1ns/100ps
module fppio_pin_model (
    input wire fppio_pkg::fppio_pins_t board_i,
    input wire fppio_pkg::fppio_byte_t [2:0] dev_pin_i,
    input wire fppio_pkg::fppio_byte_t [2:0] dev_oe_b_i,
    output fppio_pkg::fppio_pins_t wire_o
);
    // the board is resistive, so a driving device pin wins
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            wire_o.pins[p] = (dev_oe_b_i[p] & board_i.pins[p])
                | (~dev_oe_b_i[p] & dev_pin_i[p]);
        end
        wire_o.pins_d = board_i.pins_d;
    end
endmodule

// File: verification/fppio_top_monitor.sv
// concurrent checks on the ports of the four-port parallel i/o block
`timescale 1ns/100ps
module fppio_top_monitor (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [7:0] port_a_pin_o,
    input wire logic [7:0] port_a_pin_oe_b_o,
    input wire logic [7:0] input_port_pin_i,
    input wire fppio_pkg::fppio_share_t input_port_share_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_wait_one_cycle: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered in one cycle");
    a_wait_back_high: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low too long");
    a_idle_wait_high: assert property (
        !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer without request");
    a_reset_dir_clear: assert property (
        $rose(rst_b_i) |-> port_a_pin_oe_b_o == 8'hff && avs_waitrequest_o)
        else $error("reset left a pin driven");
    a_input_not_driven: assert property (
        (port_a_pin_o & port_a_pin_oe_b_o) == 8'h00) else $error("input pin driven high");
    a_dir_write_oe: assert property (
        avs_write_i && avs_waitrequest_o && avs_address_i == 8'h10 && avs_byteenable_i[0]
        |-> ##2 {24'h0, ~port_a_pin_oe_b_o} == ($past(avs_writedata_i, 2) & 32'hff))
        else $error("direction write not on enables");
    a_data_write_drive: assert property (
        avs_write_i && avs_waitrequest_o && avs_address_i == 8'h00 && avs_byteenable_i[0]
        |-> ##2 {24'h0, port_a_pin_o}
            == ($past(avs_writedata_i, 2) & {24'h0, ~port_a_pin_oe_b_o}))
        else $error("data write not on pins");
    a_read_upper_zero: assert property (
        !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
    a_share_pin_map: assert property (
        $stable(input_port_pin_i)[*8] |-> input_port_share_o == input_port_pin_i)
        else $error("shared taps differ from pins");
endmodule

bind fppio_top fppio_top_monitor mon (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .port_a_pin_o(port_a_pin_o), .port_a_pin_oe_b_o(port_a_pin_oe_b_o),
    .input_port_pin_i(input_port_pin_i), .input_port_share_o(input_port_share_o));

// File: verification/testbench.sv
// self-checking bench for the four-port parallel i/o block
`timescale 1ns/100ps
module testbench;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdata;
    logic waitreq;
    // nets, since each port lane is driven by its own output pin of the block
    wire fppio_pkg::fppio_byte_t [2:0] pin_o;
    wire fppio_pkg::fppio_byte_t [2:0] oe_b;
    fppio_pkg::fppio_pins_t board = '0;
    fppio_pkg::fppio_pins_t lvl;
    fppio_pkg::fppio_share_t share;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #2 mclk_i = ~mclk_i;
    fppio_top uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .port_a_pin_i(lvl.pins[0]), .port_a_pin_o(pin_o[0]), .port_a_pin_oe_b_o(oe_b[0]),
        .port_b_pin_i(lvl.pins[1]), .port_b_pin_o(pin_o[1]), .port_b_pin_oe_b_o(oe_b[1]),
        .port_c_pin_i(lvl.pins[2]), .port_c_pin_o(pin_o[2]), .port_c_pin_oe_b_o(oe_b[2]),
        .input_port_pin_i(lvl.pins_d), .input_port_share_o(share));
    fppio_pin_model board_u (.board_i(board), .dev_pin_i(pin_o), .dev_oe_b_i(oe_b), .wire_o(lvl));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // holds the request until waitrequest is sampled low, then releases it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] e, output logic [31:0] q);
        @(posedge mclk_i);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {24'h0, d};
        be <= e;
        do @(posedge mclk_i); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        acc(1'b0, a, 8'h00, 4'h0, q);
        chk(what, exp, q[7:0]);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
        logic [31:0] q;
        acc(1'b1, a, d, e, q);
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        board <= {8'h3c, 8'hc3, 8'h5a, 8'ha5};
        repeat (8) @(posedge mclk_i);
        chk("oe_a", 8'hff, oe_b[0]);
        rd_chk("dir_a", 8'h10, 8'h00);
        rd_chk("dir_b", 8'h14, 8'h00);
        rd_chk("dir_c", 8'h18, 8'h00);
        rd_chk("in_a", 8'h00, 8'h5a);
        rd_chk("in_b", 8'h04, 8'hc3);
        rd_chk("in_c", 8'h08, 8'h3c);
        rd_chk("in_d", 8'h0c, 8'ha5);
        chk("share", 8'ha5, share);
        $display("test reset and inputs done");
        wr_reg(8'h00, 8'h81, 4'h1);
        wr_reg(8'h04, 8'h66, 4'h1);
        wr_reg(8'h08, 8'h99, 4'h1);
        wr_reg(8'h10, 8'hff, 4'h1);
        wr_reg(8'h14, 8'h0f, 4'h1);
        wr_reg(8'h18, 8'hff, 4'h0);
        wr_reg(8'h0c, 8'h00, 4'h1);
        repeat (6) @(posedge mclk_i);
        chk("pin_a", 8'h81, pin_o[0]);
        chk("oe_b", 8'hf0, oe_b[1]);
        chk("pin_b", 8'h06, pin_o[1]);
        rd_chk("out_a", 8'h00, 8'h81);
        rd_chk("mix_b", 8'h04, 8'hc6);
        rd_chk("dir_c", 8'h18, 8'h00);
        rd_chk("ro_d", 8'h0c, 8'ha5);
        rd_chk("hole", 8'h1c, 8'h00);
        $display("test outputs done");
        rst_b_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("oe_b_rst", 8'hff, oe_b[1]);
        chk("pin_a_rst", 8'h00, pin_o[0]);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        chk("oe_a", 8'hff, oe_b[0]);
        wr_reg(8'h10, 8'hff, 4'h1);
        wr_reg(8'h18, 8'hff, 4'h1);
        rd_chk("kept_a", 8'h00, 8'h81);
        rd_chk("kept_c", 8'h08, 8'h99);
        rd_chk("kept_d", 8'h0c, 8'ha5);
        chk("pin_c", 8'h99, pin_o[2]);
        chk("oe_c", 8'h00, oe_b[2]);
        $display("test second reset done");
        wrap_up();
    end
endmodule
